// ===== pkg/card_width_pkg.sv
package card_width_pkg;

    // Register byte addresses (index times four)
    localparam logic [7:0] MODE_IDX      = 8'h20;
    localparam logic [7:0] ENH1_IDX      = 8'he0;
    localparam logic [9:0] MODE_ADDR     = 10'h080;
    localparam logic [9:0] ENH1_ADDR     = 10'h380;
    localparam logic [9:0] STATUS_ADDR   = 10'h3c0;
    localparam logic [9:0] IRQ_STAT_ADDR = 10'h3c4;
    localparam logic [9:0] IRQ_MASK_ADDR = 10'h3c8;
    localparam logic [9:0] CYCLE_ADDR    = 10'h3cc;

    // Reset values
    localparam logic [7:0] MODE_RESET    = 8'h70;
    localparam logic [7:0] ENH1_RESET    = 8'h00;
    localparam logic [3:0] MASK_RESET    = 4'h0;

    // Field positions, mode register
    localparam int MODE_S0_EN_N   = 7;
    localparam int MODE_S1_EN_N   = 6;
    localparam int MODE_ROUTE_HI  = 5;
    localparam int MODE_ROUTE_LO  = 4;
    localparam int MODE_S0_VPP    = 3;
    localparam int MODE_S0_BYTE   = 2;
    localparam int MODE_S1_VPP    = 1;
    localparam int MODE_S1_BYTE   = 0;

    // Field positions, enhancement register
    localparam int ENH_BYTE_MEM   = 4;
    localparam int ENH_CHG_SW     = 3;
    localparam int ENH_REALTIME   = 1;

    // Power sequencing time per socket
    localparam int POWER_SEQ_US   = 100;
    localparam int CLK_MHZ        = 100;
    localparam int POWER_SEQ_CYC  = POWER_SEQ_US * CLK_MHZ;

    // Card access kinds
    typedef enum logic [1:0] {ACC_EVEN, ACC_ODD, ACC_WORD} access_t;

endpackage

// ===== core/card_power_seq.sv
`timescale 1ns/1ps

module card_power_seq
    import card_width_pkg::*;
#(
    parameter int SEQ_CYCLES = POWER_SEQ_CYC
)(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic card_n_a_i,
    input  wire logic enable_i,
    output logic      done_o
);

    typedef enum {OFF, RAMP, ON} seq_state_t;

    seq_state_t  state;
    logic [31:0] count;

    // Ramp starts on insertion or socket power-on and drops back to OFF on removal
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !card_n_a_i || !enable_i)
        begin
            state <= OFF;
            count <= 32'h0;
        end
        else
        begin
            case (state)
                OFF:  state <= RAMP;
                RAMP:
                begin
                    count <= count + 32'h1;
                    if (count == 32'(SEQ_CYCLES - 1))
                        state <= ON;
                end
                ON:   state <= ON;
                default: state <= OFF;
            endcase
        end
    end

    assign done_o = (state == ON);

endmodule

// ===== core/card_lane_steer.sv
`timescale 1ns/1ps

module card_lane_steer
    import card_width_pkg::*;
(
    input  wire logic    byte_wide_i,
    input  wire access_t kind_i,
    input  wire logic    second_i,
    output logic         a0_o,
    output logic         ce2_n_o,
    output logic         ce1_n_o,
    output logic         high_buffer_enable_n_o,
    output logic         low_buffer_enable_n_o
);

    wire word16 = !byte_wide_i && (kind_i == ACC_WORD);
    wire odd16  = !byte_wide_i && (kind_i == ACC_ODD);

    // Byte-wide sockets always sit on the low lane
    assign a0_o    = byte_wide_i ? ((kind_i == ACC_ODD) || second_i)
                                 : (kind_i == ACC_ODD);
    assign ce1_n_o = odd16;
    assign ce2_n_o = !(odd16 || word16);
    // Buffer enables track the card enables
    assign high_buffer_enable_n_o = !(odd16 || word16);
    assign low_buffer_enable_n_o  = odd16;

endmodule

// ===== core/card_width_detect.sv
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps

// Operation
// - Byte-wide memory sockets exist only while enhancement bit 4 is one.
// - Mode bits 2 and 0 pick byte or word width for sockets 0 and 1.
// - Width bits steer memory cycles only, never I/O cycles.
// - With the enhancement off the width bits are inert.
// - A byte-wide socket uses the low lane with CE2 high, CE1 low.
// - A word access to a byte socket runs as even then odd byte.
// - Word sockets drive A0 and enables by even, odd or word kind.
// - Mode bit 7 enables socket 0 low, bit 6 socket 1, reset 0 and 1.
// - Mode bits 5:4 route the status interrupt to NMI, IRQ2, 6 or 7.
// - Enhancement bit 1 selects real time; change logic ignores bit 3.
// - In real-time mode card_n_a follows the detect pins at once.
// - Real-time mode keeps power sequencing after insertion.
// - In real-time mode ready reads sequencing progress.
// - Otherwise ready is the pin and card_n_a waits for sequencing.
module card_width_detect
    import card_width_pkg::*;
#(
    parameter int SEQ_CYCLES = POWER_SEQ_CYC
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             err_o,
    input  wire logic [1:0]  card_detect_n_i,
    input  wire logic [1:0]  card_ready_i,
    input  wire logic        io_cycle_i,
    input  wire logic        io_byte_wide_i,
    output logic             a0_o,
    output logic             ce2_n_o,
    output logic             ce1_n_o,
    output logic             high_buffer_enable_n_o,
    output logic             low_buffer_enable_n_o,
    output logic             busy_o,
    output logic             socket0_enable_n,
    output logic             socket1_enable_n,
    output logic             socket0_prog_supply_en,
    output logic             socket1_prog_supply_en,
    output logic             irq_nmi_o,
    output logic             irq2_o,
    output logic             irq6_o,
    output logic             irq7_o
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  mode;
    logic [7:0]  enh1;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [1:0]  det_meta;
    logic [1:0]  det_sync;
    logic [1:0]  rdy_meta;
    logic [1:0]  rdy_sync;
    logic [1:0]  card_n_a_prev;
    logic [1:0]  seq_prev;
    wire  [1:0]  seq_done;
    logic        second_half;
    logic        cycle_sock;
    access_t     cycle_kind;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire req     = cyc_i && stb_i && !ack_o && !err_o;
    wire hit_m   = adr_i == MODE_ADDR;
    wire hit_e   = adr_i == ENH1_ADDR;
    wire hit_s   = adr_i == STATUS_ADDR;
    wire hit_is  = adr_i == IRQ_STAT_ADDR;
    wire hit_im  = adr_i == IRQ_MASK_ADDR;
    wire hit_c   = adr_i == CYCLE_ADDR;
    wire mapped  = hit_m || hit_e || hit_s || hit_is || hit_im || hit_c;
    wire wr      = req && we_i && sel_i[0] && mapped;
    wire byte_en = enh1[ENH_BYTE_MEM];
    wire rt_en   = enh1[ENH_REALTIME];

    // Width bits count only with the enhancement on
    wire [1:0] byte_wide;
    assign byte_wide[0] = byte_en && mode[MODE_S0_BYTE];
    assign byte_wide[1] = byte_en && mode[MODE_S1_BYTE];

    // Detect pins are active low; card_n_a bit active low too
    wire [1:0] card_in = ~det_sync;
    wire [1:0] sock_on = {~mode[MODE_S1_EN_N], ~mode[MODE_S0_EN_N]};

    // Status view per socket
    wire [1:0] card_n_a_n;
    wire [1:0] ready_bit;
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_sock
            card_power_seq #(.SEQ_CYCLES(SEQ_CYCLES)) u_seq (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .card_n_a_i (card_in[g]),
                .enable_i  (sock_on[g]),
                .done_o    (seq_done[g])
            );
            assign card_n_a_n[g] = rt_en ? det_sync[g]
                                        : !(card_in[g] && seq_done[g]);
            assign ready_bit[g] = rt_en ? seq_done[g]
                                        : rdy_sync[g];
        end
    endgenerate

    // Status layout: ready bits sit above the card_n_a bits
    wire [7:0] status_rd = {4'h0, ready_bit, card_n_a_n};
    // Events: presence changes and sequencing completions per socket
    wire [3:0] events = {seq_done & ~seq_prev,
                         (~card_n_a_n) ^ card_n_a_prev};
    wire [3:0] next_irq_stat = (irq_stat & ~((wr && hit_is) ? dat_i[3:0]
                                                            : 4'h0))
                               | events;  // Set wins over clear

    // Unmapped offsets read zero, but they answer with err instead of ack
    wire [31:0] rd_mux = hit_m  ? {24'h0, mode} :
                         hit_e  ? {24'h0, enh1} :
                         hit_s  ? {24'h0, status_rd} :
                         hit_is ? {28'h0, irq_stat} :
                         hit_im ? {28'h0, irq_mask} :
                         hit_c  ? {29'h0, busy_o, cycle_sock, 1'b0} :
                                  32'h0;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge clk_i)
    begin
        det_meta <= card_detect_n_i;
        det_sync <= det_meta;
        rdy_meta <= card_ready_i;
        rdy_sync <= rdy_meta;
    end

    // Bus answer: one cycle after request, err on unmapped
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            ack_o <= req && mapped;
            err_o <= req && !mapped;
            dat_o <= rd_mux;
        end
    end

    // Control registers; status register writes ignored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode     <= MODE_RESET;
            enh1     <= ENH1_RESET;
            irq_mask <= MASK_RESET;
        end
        else if (wr)
        begin
            if (hit_m)
                mode <= dat_i[7:0];
            if (hit_e)
                enh1 <= dat_i[7:0];
            if (hit_im)
                irq_mask <= dat_i[3:0];
        end // hit_s never written
    end

    // Interrupt status tracking
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat     <= 4'h0;
            card_n_a_prev <= 2'h0;
            seq_prev     <= 2'h0;
        end
        else
        begin
            irq_stat     <= next_irq_stat;
            card_n_a_prev <= ~card_n_a_n;
            seq_prev     <= seq_done;
        end
    end

    // Status interrupt routed by the mode field
    wire irq_any = |(irq_stat & irq_mask);
    wire [1:0] route = {mode[MODE_ROUTE_HI], mode[MODE_ROUTE_LO]};
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            {irq_nmi_o, irq2_o, irq6_o, irq7_o} <= 4'h0;
        end
        else
        begin
            irq_nmi_o <= irq_any && (route == 2'h0);
            irq2_o    <= irq_any && (route == 2'h1);
            irq6_o    <= irq_any && (route == 2'h2);
            irq7_o    <= irq_any && (route == 2'h3);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Card cycle sequencer: a write to the cycle register launches one
    // access; bits 1:0 kind, bit 2 socket. I/O cycles keep their own width.
    wire mem_wide8 = io_cycle_i ? io_byte_wide_i
                                : byte_wide[cycle_sock];
    wire split     = mem_wide8 && (cycle_kind == ACC_WORD);
    wire start     = wr && hit_c && !busy_o;
    wire        s_a0, s_ce2, s_ce1, s_hb, s_lb;

    card_lane_steer u_steer (
        .byte_wide_i            (mem_wide8),
        .kind_i                 (cycle_kind),
        .second_i               (second_half),
        .a0_o                   (s_a0),
        .ce2_n_o                (s_ce2),
        .ce1_n_o                (s_ce1),
        .high_buffer_enable_n_o (s_hb),
        .low_buffer_enable_n_o  (s_lb)
    );

    // A split word keeps busy one extra cycle for its odd half
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_o      <= 1'b0;
            second_half <= 1'b0;
            cycle_sock  <= 1'b0;
            cycle_kind  <= ACC_EVEN;
        end
        else if (start)
        begin
            busy_o     <= 1'b1;
            cycle_sock <= dat_i[2];
            cycle_kind <= access_t'(dat_i[1:0]);
        end
        else if (busy_o && split && !second_half)
            second_half <= 1'b1;
        else
        begin
            busy_o      <= 1'b0;
            second_half <= 1'b0;
        end
    end

    // Card enables and buffer enables idle high, A0 low, when no cycle runs
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !busy_o)
        begin
            a0_o <= 1'b0;
            {ce2_n_o, ce1_n_o} <= 2'h3;
            {high_buffer_enable_n_o, low_buffer_enable_n_o} <= 2'h3;
        end
        else
        begin
            a0_o <= s_a0;
            ce2_n_o <= s_ce2;
            ce1_n_o <= s_ce1;
            high_buffer_enable_n_o <= s_hb;
            low_buffer_enable_n_o <= s_lb;
        end
    end

    // Socket enables and supply switches follow the mode bits a cycle late
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            socket0_enable_n <= 1'b0;
            socket1_enable_n <= 1'b1;
            socket0_prog_supply_en <= 1'b0;
            socket1_prog_supply_en <= 1'b0;
        end
        else
        begin
            socket0_enable_n <= mode[MODE_S0_EN_N];
            socket1_enable_n <= mode[MODE_S1_EN_N];
            socket0_prog_supply_en <= mode[MODE_S0_VPP];
            socket1_prog_supply_en <= mode[MODE_S1_VPP];
        end
    end

endmodule

// ===== dv/card_width_detect_properties.sv
`timescale 1ns/1ps

// Watches the bus handshake, lane enables and interrupt routing
module card_width_detect_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic err_o,
    input wire logic ce2_n_o,
    input wire logic ce1_n_o,
    input wire logic high_buffer_enable_n_o,
    input wire logic low_buffer_enable_n_o,
    input wire logic socket0_enable_n,
    input wire logic socket1_enable_n,
    input wire logic irq_nmi_o,
    input wire logic irq2_o,
    input wire logic irq6_o,
    input wire logic irq7_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held past one cycle");
    chk_err_pulse: assert property (err_o |=> !err_o)
        else $error("err held past one cycle");
    chk_take_answer: assert property
        (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
        else $error("request not answered in one cycle");
    chk_answer_cause: assert property
        (ack_o || err_o |-> $past(cyc_i && stb_i))
        else $error("answer without a request");
    chk_resp_excl: assert property (!(ack_o && err_o))
        else $error("ack and err together");
    chk_high_buffer: assert property (high_buffer_enable_n_o == ce2_n_o)
        else $error("high buffer enable off its card enable");
    chk_low_buffer: assert property (low_buffer_enable_n_o == ce1_n_o)
        else $error("low buffer enable off its card enable");
    chk_irq_route: assert property
        ($onehot0({irq_nmi_o, irq2_o, irq6_o, irq7_o}))
        else $error("status interrupt on several lines");
    chk_reset_enables: assert property
        ($fell(rst_i) |-> !socket0_enable_n && socket1_enable_n)
        else $error("socket enables wrong after reset");
endmodule

bind card_width_detect card_width_detect_properties chk (
    .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .err_o, .ce2_n_o, .ce1_n_o,
    .high_buffer_enable_n_o, .low_buffer_enable_n_o, .socket0_enable_n,
    .socket1_enable_n, .irq_nmi_o, .irq2_o, .irq6_o, .irq7_o);

// ===== dv/card_socket_model.sv
`timescale 1ns/1ps

// Cards in both sockets; an empty socket leaves its pulled-up pins high
module card_socket_model (
    input  wire logic       clk_i,
    input  wire logic [1:0] insert_i,
    input  wire logic [1:0] stall_i,
    output logic      [1:0] card_detect_n_o = 2'b11,
    output logic      [1:0] card_ready_o    = 2'b11
);
    // Contacts settle one clock after the bench moves a card
    always_ff @(posedge clk_i)
    begin
        card_detect_n_o <= ~insert_i;
        card_ready_o    <= ~insert_i | ~stall_i; // Slow card holds busy
    end
endmodule

// ===== dv/card_width_detect_test.sv
`timescale 1ns/1ps

module card_width_detect_test
    import card_width_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0, io_cycle_i = 1'b0, io_byte_wide_i = 1'b0;
    logic [9:0]  adr_i = 10'h000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [1:0]  insert = 2'b00, stall = 2'b00, det_n, rdy;
    logic        ack_o, err_o, a0_o, ce2_n_o, ce1_n_o, busy_o, last_err;
    logic        high_buffer_enable_n_o, low_buffer_enable_n_o;
    logic        socket0_enable_n, socket1_enable_n, irq_nmi_o, irq2_o;
    logic        socket0_prog_supply_en, socket1_prog_supply_en;
    logic        irq6_o, irq7_o;
    int          miscompares = 0, n_compared = 0;
    wire  [3:0]  irqs = {irq_nmi_o, irq2_o, irq6_o, irq7_o};

    always #5 clk_i = ~clk_i;

    card_width_detect #(.SEQ_CYCLES(8)) dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .err_o, .card_detect_n_i(det_n),
        .card_ready_i(rdy), .io_cycle_i, .io_byte_wide_i, .a0_o, .ce2_n_o,
        .ce1_n_o, .high_buffer_enable_n_o, .low_buffer_enable_n_o, .busy_o,
        .socket0_enable_n, .socket1_enable_n, .socket0_prog_supply_en,
        .socket1_prog_supply_en, .irq_nmi_o, .irq2_o, .irq6_o, .irq7_o);
    card_socket_model card (.clk_i, .insert_i(insert), .stall_i(stall),
        .card_detect_n_o(det_n), .card_ready_o(rdy));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // One classic cycle; the request stands until ack or err is sampled
    task automatic wb(input logic w, input logic [9:0] a,
                      input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'h1;
        adr_i <= a;
        dat_i <= {24'h0, d};
        // No limit here: only the watchdog ends a wait for the answer
        do
        begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        q = dat_o;
        last_err = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    // Reads status until bit b shows v; n counts the reads taken
    task automatic poll(input int b, input logic v, output int n,
                        output logic [31:0] q);
        n = 0;
        do
        begin
            wb(1'b0, STATUS_ADDR, 8'h00, q);
            n++;
        end while (q[b] !== v && n < 30);
        // Running out of reads counts as a mismatch
        if (q[b] !== v)
        begin
            miscompares++;
            $display("[FAIL] %0t status bit %0d never settled", $time, b);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] q;
        wb(1'b0, MODE_ADDR, 8'h00, q);
        chk(q, 32'h70);
        wb(1'b0, ENH1_ADDR, 8'h00, q);
        chk(q, 32'h00);
        chk({socket0_enable_n, socket1_enable_n, irqs}, 6'b010000);
        wr(MODE_ADDR, 8'h0a);
        wb(1'b0, MODE_ADDR, 8'h00, q);
        chk(q, 32'h0a);
        chk({socket0_enable_n, socket1_enable_n, socket0_prog_supply_en,
             socket1_prog_supply_en}, 4'b0011);
        wb(1'b0, 10'h004, 8'h00, q);
        chk(last_err, 1'b1);
    endtask

    // Every socket, width, enhancement, I/O and access kind in turn
    task automatic t_width();
        logic [3:0] j;
        logic [2:0] e;
        logic       bw;
        int         k;
        for (int i = 0; i < 48; i++)
        begin
            j = 4'(i / 3);
            k = i % 3;
            wr(ENH1_ADDR, {3'b000, j[2], 4'h0});
            io_cycle_i <= j[3];
            io_byte_wide_i <= j[1];
            wr(MODE_ADDR, j[1] ^ j[0] ? 8'h34 : 8'h31);
            wr(CYCLE_ADDR, {5'h0, j[0], 2'(k)});
            bw = j[3] ? j[1] : j[2] & j[1];
            e = bw ? {k == 1, 2'b10} :
                (k == 0 ? 3'b010 : (k == 1 ? 3'b101 : 3'b000));
            // Pins show in the cycle after ack; busy is still high then only
            // for the split word
            #1;
            chk({busy_o, a0_o, ce2_n_o, ce1_n_o},
                {bw && k == 2, e});
            chk({high_buffer_enable_n_o, low_buffer_enable_n_o},
                e[1:0]);
            if (bw && k == 2)
            begin
                @(posedge clk_i);
                #1;
                chk({busy_o, a0_o, ce2_n_o, ce1_n_o}, 4'b0110);
            end
            // Pins fall back to idle once the access is over
            @(posedge clk_i);
            #1;
            chk({busy_o, a0_o, ce2_n_o, ce1_n_o}, 4'b0011);
        end
    endtask

    task automatic t_detect(input logic rt);
        logic [31:0] q, q1;
        int          n;
        wr(ENH1_ADDR, {6'h0, rt, 1'b0});
        insert <= 2'b00;
        poll(0, 1'b1, n, q);
        insert <= 2'b01;
        poll(0, 1'b0, n, q);
        if (rt)
        begin
            chk({n <= 2, q[2]}, 2'b10);
            poll(2, 1'b1, n, q);
            chk({n > 1, q[2]}, 2'b11);
        end
        else
        begin
            chk(n > 2, 1'b1);
            stall <= 2'b01;
            poll(2, 1'b0, n, q);
            chk(n <= 3, 1'b1);
            stall <= 2'b00;
            poll(2, 1'b1, n, q);
            wr(STATUS_ADDR, ~q[7:0]);
            wb(1'b0, STATUS_ADDR, 8'h00, q1);
            chk(q1, q);
        end
    endtask

    // Presence change is pending; route, unmask, then clear it
    task automatic t_irq();
        int n;
        for (int i = 0; i < 4; i++)
        begin
            wr(MODE_ADDR, {2'b00, 2'(i), 4'h0});
            wr(IRQ_MASK_ADDR, 8'h01);
            for (n = 0; irqs === 4'h0 && n < 8; n++)
                @(posedge clk_i);
            #1;
            chk(irqs, 4'b1000 >> i);
            wr(IRQ_MASK_ADDR, 8'h00);
        end
        wr(IRQ_STAT_ADDR, 8'h0f);
        wr(IRQ_MASK_ADDR, 8'h0f);
        repeat (3) @(posedge clk_i);
        #1;
        chk(irqs, 4'h0);
    endtask

    task automatic complete_run();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_width();
        t_detect(1'b1);
        t_detect(1'b0);
        t_irq();
        complete_run();
    end

    // The whole sequence needs a few thousand cycles at most
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule
